// [hw/bpc_compressor.sv]
// branch packet compressor: builds one branch target packet per accepted
// branch and streams it out a byte at a time.
// assumes one clock, an asynchronous active-low reset, and a byte sink
// on the same clock that may stall with out_ready.
module bpc_compressor (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  wire logic                  cyc_acc_en,
  input  wire logic                  core_cycle_en,
  input  wire logic                  br_valid,
  output logic                       br_ready,
  input  wire bpc_pkg::bpc_branch_t  br_req,
  input  wire logic                  sync_valid,
  input  wire bpc_pkg::bpc_sync_t    sync_req,
  output logic                       out_valid,
  input  wire logic                  out_ready,
  output logic [7:0]                 out_byte,
  output logic                       out_first,
  output logic                       out_last,
  output logic [bpc_pkg::CNT_W-1:0]  cyc_count
);

  typedef enum logic {
    ST_IDLE,
    ST_SEND
  } bpc_state_t;

  bpc_state_t                                  state_q;
  logic [bpc_pkg::PKT_MAX-1:0][7:0]            pkt_q;
  logic [bpc_pkg::PKT_MAX-1:0][7:0]            pkt_d;
  logic [bpc_pkg::LEN_W-1:0]                   left_q;
  logic [bpc_pkg::LEN_W-1:0]                   len_d;
  logic                                        first_q;
  logic [bpc_pkg::CNT_W-1:0]                   cnt_q;
  logic [bpc_pkg::ADDR_W-1:0]                  ref_addr_q;
  bpc_pkg::bpc_isa_t                           ref_isa_q;
  logic                                        ref_ns_q;
  logic                                        ref_alt_q;
  logic                                        ref_valid_q;
  logic                                        accept;
  logic                                        take;
  logic                                        alt_eff;
  logic                                        exc_need;
  logic                                        exc_ext;
  logic                                        align_chg;
  logic [bpc_pkg::LEN_W-1:0]                   addr_len;
  logic [bpc_pkg::ADDR_W-1:0]                  sh_addr;
  logic [bpc_pkg::CNT_W-1:0]                   cnt_report;
  logic [4:0][7:0]                             cyc_bytes;
  logic [bpc_pkg::LEN_W-1:0]                   cyc_len;

  // bit position of address bit 0 of byte 0 for each alignment
  function automatic int unsigned isa_shift(bpc_pkg::bpc_isa_t isa);
    case (isa)
      bpc_pkg::BPC_ISA_WORD: isa_shift = 2;
      bpc_pkg::BPC_ISA_HALF: isa_shift = 1;
      default:               isa_shift = 0;
    endcase
  endfunction : isa_shift

  // low six bits of address byte 4: alignment marker and top address bits
  function automatic logic [5:0] top_field(bpc_pkg::bpc_isa_t isa,
                                           logic [31:0] a);
    case (isa)
      bpc_pkg::BPC_ISA_WORD: top_field = {3'b001, a[31:29]};
      bpc_pkg::BPC_ISA_HALF: top_field = {2'b01, a[31:28]};
      default:               top_field = {1'b1, a[31:27]};
    endcase
  endfunction : top_field

  // minimum address bytes for the changed bits after alignment shift
  function automatic logic [3:0] changed_len(logic [31:0] diff_sh);
    if (diff_sh[31:bpc_pkg::THR_5] != '0) begin
      changed_len = 4'h5;
    end else if (diff_sh[bpc_pkg::THR_5-1:bpc_pkg::THR_4] != '0) begin
      changed_len = 4'h4;
    end else if (diff_sh[bpc_pkg::THR_4-1:bpc_pkg::THR_3] != '0) begin
      changed_len = 4'h3;
    end else if (diff_sh[bpc_pkg::THR_3-1:bpc_pkg::THR_2] != '0) begin
      changed_len = 4'h2;
    end else begin
      changed_len = 4'h1;
    end
  endfunction : changed_len

  // a new branch is taken only while nothing is being sent
  assign br_ready = (state_q == ST_IDLE);
  assign accept   = br_valid && br_ready;
  assign take     = out_valid && out_ready;

  // count reported with this packet: zero for a same-cycle branch
  assign cnt_report = br_req.same_cycle ? bpc_pkg::CNT_RST : cnt_q;
  assign cyc_count  = cnt_q;

  bpc_cyc_enc u_cyc_enc (
    .count (cnt_report),
    .bytes (cyc_bytes),
    .len   (cyc_len)
  );

  // alternate flag is only meaningful for the halfword state
  assign alt_eff = (br_req.isa == bpc_pkg::BPC_ISA_HALF) &&
                   br_req.alternate_isa_flag;

  // exception bytes: an exception, or a security/alternate flag change
  assign exc_need = (br_req.exc_num != 9'h000) ||
                    (br_req.nonsecure_flag != ref_ns_q) ||
                    (alt_eff != ref_alt_q);
  assign exc_ext  = br_req.exc_num > bpc_pkg::EXC_ONE_BYTE_MAX;

  // alignment change (or no reference yet) defeats compression
  assign align_chg = !ref_valid_q || (br_req.isa != ref_isa_q);

  // address bits seen from the low bit of the byte-0 field
  assign sh_addr = br_req.addr >> isa_shift(br_req.isa);

  // address section length
  always_comb begin
    addr_len = changed_len((br_req.addr ^ ref_addr_q) >>
                           isa_shift(br_req.isa));
    if (exc_need && addr_len < bpc_pkg::ADDR_LEN_EXC) begin
      addr_len = bpc_pkg::ADDR_LEN_EXC;
    end
    // bytecode targets and alignment changes always go out whole
    if (align_chg || br_req.isa == bpc_pkg::BPC_ISA_BYTE) begin
      addr_len = bpc_pkg::ADDR_LEN_FULL;
    end
  end

  // assemble the whole packet: address, exception, then cycle count
  always_comb begin
    logic [bpc_pkg::LEN_W-1:0] pos;
    logic                      last;
    pkt_d = '0;
    pos   = '0;
    last  = 1'b0;
    // header byte: marker in bit 0, continuation in bit 7
    pkt_d[0] = {(addr_len > bpc_pkg::ADDR_LEN_MIN), sh_addr[5:0],
                1'b1};
    // address bytes 1 to 3: seven bits, or six plus exception flag
    for (int k = 1; k < 4; k++) begin
      last = (addr_len == 4'(k + 1));
      if (4'(k) < addr_len) begin
        if (last) begin
          pkt_d[k] = {1'b0, exc_need,
                      sh_addr[6 + 7 * (k - 1) +: 6]};
        end else begin
          pkt_d[k] = {1'b1, sh_addr[6 + 7 * (k - 1) +: 7]};
        end
      end
    end
    // address byte 4 is always last and carries the alignment
    if (addr_len == bpc_pkg::ADDR_LEN_FULL) begin
      pkt_d[4] = {1'b0, exc_need,
                  top_field(br_req.isa, br_req.addr)};
    end
    pos = addr_len;
    // exception information bytes
    if (exc_need) begin
      pkt_d[pos] = {exc_ext, alt_eff, 1'b0, br_req.exc_num[3:0],
                    br_req.nonsecure_flag};
      pos = pos + 4'h1;
      if (exc_ext) begin
        pkt_d[pos] = {2'b00, br_req.hyp, br_req.exc_num[8:4]};
        pos = pos + 4'h1;
      end
    end
    // cycle count bytes follow the packet directly
    if (cyc_acc_en) begin
      for (int i = 0; i < 5; i++) begin
        if (4'(i) < cyc_len) begin
          pkt_d[pos + 4'(i)] = cyc_bytes[i];
        end
      end
      pos = pos + cyc_len;
    end
    len_d = pos;
  end

  // send state: idle until accepted, back when the last byte leaves
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (accept) begin
            state_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (take && left_q == 4'h1) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // packet shift register: the head byte always drives out_byte
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pkt_q   <= '0;
      left_q  <= '0;
      first_q <= 1'b0;
    end else if (accept) begin
      pkt_q   <= pkt_d;
      left_q  <= len_d;
      first_q <= 1'b1;
    end else if (take) begin
      pkt_q   <= {8'h00, pkt_q[bpc_pkg::PKT_MAX-1:1]};
      left_q  <= left_q - 4'h1;
      first_q <= 1'b0;
    end
  end

  assign out_valid = (state_q == ST_SEND);
  assign out_byte  = pkt_q[0];
  assign out_first = out_valid && first_q;
  assign out_last  = out_valid && (left_q == 4'h1);

  // cycle counter: restarts at each packet, sticks at all ones
  // a same-cycle branch leaves it running so nothing is lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= bpc_pkg::CNT_RST;
    end else if (!cyc_acc_en) begin
      cnt_q <= bpc_pkg::CNT_RST;
    end else if (accept && !br_req.same_cycle) begin
      cnt_q <= core_cycle_en ? 32'h0000_0001 : bpc_pkg::CNT_RST;
    end else if (core_cycle_en && cnt_q != bpc_pkg::CNT_SAT) begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // compression reference: last branch packet or instruction sync
  // a sync in the same cycle as a branch loses to the branch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ref_addr_q  <= bpc_pkg::REF_ADDR_RST;
      ref_isa_q   <= bpc_pkg::BPC_ISA_WORD;
      ref_ns_q    <= 1'b0;
      ref_alt_q   <= 1'b0;
      ref_valid_q <= 1'b0;
    end else if (accept) begin
      ref_addr_q  <= br_req.addr;
      ref_isa_q   <= br_req.isa;
      ref_ns_q    <= br_req.nonsecure_flag;
      ref_alt_q   <= alt_eff;
      ref_valid_q <= 1'b1;
    end else if (sync_valid) begin
      ref_addr_q  <= sync_req.addr;
      ref_isa_q   <= sync_req.isa;
      ref_ns_q    <= sync_req.nonsecure_flag;
      ref_alt_q   <= (sync_req.isa == bpc_pkg::BPC_ISA_HALF) &&
                     sync_req.alternate_isa_flag;
      ref_valid_q <= 1'b1;
    end
  end

endmodule : bpc_compressor

// [pkg/bpc_pkg.sv]
// branch packet compressor package: widths, reset values, thresholds,
// instruction alignment states and the request carriers.
// assumes nothing beyond a SystemVerilog compiler; imported by name only.
package bpc_pkg;

  // widths of the address and the cycle counter
  localparam int ADDR_W  = 32;
  localparam int CNT_W   = 32;
  // address bytes 1-5, exception bytes 0-2, cycle count bytes 0-5
  localparam int PKT_MAX = 12;
  localparam int LEN_W   = 4;

  // counter value that reports an overflow
  localparam logic [CNT_W-1:0] CNT_SAT     = 32'hffff_ffff;
  localparam logic [CNT_W-1:0] CNT_RST     = 32'h0000_0000;
  localparam logic [ADDR_W-1:0] REF_ADDR_RST = 32'h0000_0000;

  // address and cycle count section length limits
  localparam logic [LEN_W-1:0] ADDR_LEN_MIN  = 4'h1;
  localparam logic [LEN_W-1:0] ADDR_LEN_EXC  = 4'h2;
  localparam logic [LEN_W-1:0] ADDR_LEN_FULL = 4'h5;
  localparam logic [LEN_W-1:0] CYC_LEN_MAX   = 4'h5;

  // first shifted-address bit that forces 2, 3, 4 and 5 address bytes
  localparam int THR_2 = 6;
  localparam int THR_3 = 12;
  localparam int THR_4 = 19;
  localparam int THR_5 = 26;

  // cycle count field starts: byte 0 holds [3:0], then 7 bits each
  localparam int CYC_B1 = 4;
  localparam int CYC_B2 = 11;
  localparam int CYC_B3 = 18;
  localparam int CYC_B4 = 25;

  // exception numbers above this need the second exception byte
  localparam logic [8:0] EXC_ONE_BYTE_MAX = 9'h00f;

  // instruction alignment state of the branch target
  typedef enum logic [1:0] {
    BPC_ISA_WORD,
    BPC_ISA_HALF,
    BPC_ISA_BYTE
  } bpc_isa_t;

  // one retired branch as offered by the processor side
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    bpc_isa_t          isa;
    logic              alternate_isa_flag;
    logic              nonsecure_flag;
    logic              hyp;
    logic [8:0]        exc_num;
    logic              same_cycle;
  } bpc_branch_t;

  // reference point set by an instruction-sync packet elsewhere
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    bpc_isa_t          isa;
    logic              alternate_isa_flag;
    logic              nonsecure_flag;
  } bpc_sync_t;

endpackage : bpc_pkg

// [hw/bpc_cyc_enc.sv]
// cycle count encoder: leading-zero compressed count bytes.
// assumes the count is already saturated by the caller; purely combinational.
module bpc_cyc_enc (
  input  wire logic [bpc_pkg::CNT_W-1:0] count,
  output logic      [4:0][7:0]           bytes,
  output logic      [bpc_pkg::LEN_W-1:0] len
);

  // shortest byte count that still holds every set bit
  always_comb begin
    if (count[bpc_pkg::CNT_W-1:bpc_pkg::CYC_B4] != '0) begin
      len = 4'h5;
    end else if (count[bpc_pkg::CYC_B4-1:bpc_pkg::CYC_B3] != '0) begin
      len = 4'h4;
    end else if (count[bpc_pkg::CYC_B3-1:bpc_pkg::CYC_B2] != '0) begin
      len = 4'h3;
    end else if (count[bpc_pkg::CYC_B2-1:bpc_pkg::CYC_B1] != '0) begin
      len = 4'h2;
    end else begin
      len = 4'h1;
    end
  end

  // continuation flag set on all but the last byte
  always_comb begin
    bytes[0] = {1'b0, (len > 4'h1), count[3:0], 2'b00};
    bytes[1] = {(len > 4'h2), count[10:4]};
    bytes[2] = {(len > 4'h3), count[17:11]};
    bytes[3] = {(len > 4'h4), count[24:18]};
    bytes[4] = {1'b0, count[31:25]}; // last byte never continues
  end

endmodule : bpc_cyc_enc

// [tb/bpc_chk.sv]
// port checker for the branch packet compressor, bound to its top module.
// assumes one clock domain with rst_n asynchronous and active low.
module bpc_chk (
  input wire logic                     clk_sys,
  input wire logic                     rst_n,
  input wire logic                     cyc_acc_en,
  input wire logic                     core_cycle_en,
  input wire logic                     br_valid,
  input wire logic                     br_ready,
  input wire logic                     out_valid,
  input wire logic                     out_ready,
  input wire logic [7:0]               out_byte,
  input wire logic                     out_first,
  input wire logic                     out_last,
  input wire logic [bpc_pkg::CNT_W-1:0] cyc_count
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [3:0] nb_q;
  wire        tk = br_valid && br_ready;
  // bytes taken so far in the packet; a runaway packet shows up here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) nb_q <= 4'h0;
    else if (out_valid && out_ready) nb_q <= out_last ? 4'h0 : nb_q + 4'h1;
  end
  property p_hdr; tk |=> out_valid && out_first && out_byte[0]; endproperty
  a_hdr: assert property (p_hdr) else $error("no header");
  property p_one;
    out_valid && out_first && !out_byte[7] && !cyc_acc_en |-> out_last;
  endproperty
  a_one: assert property (p_one) else $error("lone byte not last");
  property p_ca;
    out_valid && out_first && !out_byte[7] && cyc_acc_en |-> !out_last;
  endproperty
  a_ca: assert property (p_ca) else $error("count byte missing");
  property p_more;
    out_valid && out_first && out_byte[7] |-> !out_last;
  endproperty
  a_more: assert property (p_more) else $error("header says more");
  property p_hold;
    out_valid && !out_ready |=>
      out_valid && $stable(out_byte) && $stable(out_last);
  endproperty
  a_hold: assert property (p_hold) else $error("byte moved");
  // a header flag left over from the previous byte would misframe the sink
  property p_nfst;
    out_valid && out_ready && !out_last |=> !out_first;
  endproperty
  a_nfst: assert property (p_nfst) else $error("first twice");
  property p_len; out_valid |-> nb_q < 4'hc; endproperty
  a_len: assert property (p_len) else $error("packet too long");
  property p_done;
    out_valid && out_ready && out_last |=> !out_valid && br_ready;
  endproperty
  a_done: assert property (p_done) else $error("not idle");
  property p_off; !cyc_acc_en [*2] |-> cyc_count == 32'h0; endproperty
  a_off: assert property (p_off) else $error("count not held");
  property p_inc;
    cyc_acc_en && core_cycle_en && !tk && cyc_count != 32'hffffffff
      |=> cyc_count == $past(cyc_count) + 32'h1;
  endproperty
  a_inc: assert property (p_inc) else $error("count missed");
  property p_sat; cyc_acc_en && !tk && cyc_count == 32'hffffffff
    |=> cyc_count == 32'hffffffff; endproperty
  a_sat: assert property (p_sat) else $error("counter wrapped");
  c_take: cover property (tk);
  c_ca: cover property (tk && cyc_acc_en);
  c_stall: cover property (out_valid && !out_ready);
endmodule : bpc_chk

bind bpc_compressor bpc_chk u_chk (.clk_sys, .rst_n, .cyc_acc_en,
  .core_cycle_en, .br_valid, .br_ready, .out_valid, .out_ready, .out_byte,
  .out_first, .out_last, .cyc_count);

// [tb/bpc_sink.sv]
// trace byte sink model: takes bytes, may stall every other cycle.
// assumes the compressor's clock and reset; the bench reads pkt and len.
module bpc_sink (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       stall,
  input  wire logic       out_valid,
  output logic            out_ready,
  input  wire logic [7:0] out_byte,
  input  wire logic       out_last
);
  logic [7:0] pkt [12];
  logic [3:0] idx, len;
  logic [7:0] n_pkt;
  logic       tog;
  // stall pattern is free-running so stalls land on any byte position
  assign out_ready = !stall || tog;
  // packets are framed by the last flag only, as a real sink would be
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idx <= 4'h0;
      len <= 4'h0;
      n_pkt <= 8'h00;
      tog <= 1'h0;
    end else begin
      tog <= !tog;
      if (out_valid && out_ready) begin
        pkt[idx] <= out_byte;
        idx <= out_last ? 4'h0 : idx + 4'h1;
        if (out_last) len <= idx + 4'h1;
        if (out_last) n_pkt <= n_pkt + 8'h01;
      end
    end
  end
endmodule : bpc_sink

// [tb/testbench.sv]
// self-checking bench for the branch packet compressor.
// assumes the checker is bound by its own file; byte sink is bpc_sink.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [3:0]  fl;  // sync first, cycle mode, same cycle, hyp
    logic [7:0]  np;  // core cycles before the branch
    logic [1:0]  isa;
    logic [1:0]  an;  // alternate, nonsecure
    logic [8:0]  ex;
    logic [31:0] a;
    logic [3:0]  n;   // expected byte count
    logic [47:0] b;   // expected bytes, first in the top byte
  } bpc_row_t;
  // ordinary cases run in order; each row leans on the reference it inherits
  localparam bpc_row_t ROWS [14] = '{
    '{4'h0, 8'h00, 2'h0, 2'h0, 9'h000, 32'h0, 4'h5, 48'h818080800800},
    '{4'h0, 8'h00, 2'h0, 2'h0, 9'h000, 32'h4, 4'h1, 48'h030000000000},
    '{4'h0, 8'h00, 2'h0, 2'h0, 9'h000, 32'h104, 4'h2, 48'h830100000000},
    '{4'h0, 8'h00, 2'h0, 2'h0, 9'h00a, 32'h104, 4'h3, 48'h834114000000},
    '{4'h1, 8'h00, 2'h0, 2'h0, 9'h015, 32'h104, 4'h4, 48'h83418a210000},
    '{4'h0, 8'h00, 2'h0, 2'h1, 9'h000, 32'h104, 4'h3, 48'h834101000000},
    '{4'h0, 8'h00, 2'h1, 2'h1, 9'h000, 32'h2, 4'h5, 48'h838080801000},
    '{4'h0, 8'h00, 2'h2, 2'h1, 9'h000, 32'h12345678, 4'h5, 48'hf1d9a2a32200},
    '{4'h0, 8'h00, 2'h1, 2'h3, 9'h000, 32'h2, 4'h6, 48'h838080805041},
    '{4'h0, 8'h00, 2'h1, 2'h3, 9'h000, 32'h4, 4'h1, 48'h050000000000},
    '{4'h0, 8'h00, 2'h1, 2'h3, 9'h000, 32'hf0000004, 4'h5, 48'h858080801f00},
    '{4'hc, 8'h00, 2'h0, 2'h1, 9'h000, 32'h104, 4'h2, 48'h030000000000},
    '{4'h4, 8'h15, 2'h0, 2'h1, 9'h000, 32'h104, 4'h3, 48'h035401000000},
    '{4'h6, 8'h03, 2'h0, 2'h1, 9'h000, 32'h104, 4'h2, 48'h030000000000}};
  logic clk_sys, rst_n, cyc_acc_en, core_cycle_en, br_valid, br_ready;
  logic sync_valid, out_valid, out_ready, out_first, out_last, stall;
  logic [7:0]              out_byte;
  logic [31:0]             cyc_count;
  bpc_pkg::bpc_branch_t    br_req;
  bpc_pkg::bpc_sync_t      sync_req;
  int                      n_errors, total_checks;
  bpc_compressor uut (.clk_sys, .rst_n, .cyc_acc_en, .core_cycle_en,
    .br_valid, .br_ready, .br_req, .sync_valid, .sync_req, .out_valid,
    .out_ready, .out_byte, .out_first, .out_last, .cyc_count);
  bpc_sink u_sink (.clk_sys, .rst_n, .stall, .out_valid, .out_ready,
    .out_byte, .out_last);
  task automatic conclude();
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  // one branch: core cycles, optional sync, then the request held until taken
  task automatic run(input bpc_row_t r);
    logic [7:0] p;
    p = u_sink.n_pkt;
    cyc_acc_en <= r.fl[2];
    repeat (r.np) begin
      @(posedge clk_sys);
      core_cycle_en <= 1'h1;
      @(posedge clk_sys);
      core_cycle_en <= 1'h0;
    end
    if (r.fl[3]) begin
      sync_req <= '{r.a - 32'h4, bpc_pkg::bpc_isa_t'(r.isa), 1'h0, r.an[0]};
      sync_valid <= 1'h1;
      @(posedge clk_sys);
      sync_valid <= 1'h0;
    end
    br_req <= '{r.a, bpc_pkg::bpc_isa_t'(r.isa), r.an[1], r.an[0], r.fl[0],
                r.ex, r.fl[1]};
    br_valid <= 1'h1;
    // ready is looked at off the edge, so its update at the taking edge
    // cannot race the bench
    @(negedge clk_sys);
    while (br_ready !== 1'h1) @(negedge clk_sys);
    @(posedge clk_sys);
    br_valid <= 1'h0;
    wait (u_sink.n_pkt != p);
    @(negedge clk_sys);
    chk({4'h0, u_sink.len}, {4'h0, r.n});
    for (int k = 0; k < r.n; k++) begin
      chk(u_sink.pkt[k], r.b[47-8*k -: 8]);
    end
  endtask : run
  initial begin
    clk_sys = 1'h0;
    forever #20 clk_sys = ~clk_sys;
  end
  // watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    conclude();
  end
  initial begin
    {rst_n, cyc_acc_en, core_cycle_en, br_valid, sync_valid, stall} = 6'h0;
    br_req = '0;
    sync_req = '0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'h1;
    for (int i = 0; i < 14; i++) begin
      @(posedge clk_sys);
      stall <= i[0];
      run(ROWS[i]);
    end
    // reset in mid-packet: outputs idle and the reference is forgotten
    @(posedge clk_sys);
    br_valid <= 1'h1;
    @(posedge clk_sys);
    br_valid <= 1'h0;
    @(posedge clk_sys);
    rst_n <= 1'h0;
    @(negedge clk_sys);
    chk({6'h0, out_valid, br_ready}, 8'h01);
    chk({7'h0, |cyc_count}, 8'h00);
    @(posedge clk_sys);
    rst_n <= 1'h1;
    run(ROWS[0]);
    conclude();
  end
endmodule : testbench
